//--- logic/ost_pkg.sv
// package: register map, fields, timing constants for oscillator control block
package ost_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_OSC_CONTROL = 4'h0;
  localparam logic [3:0] OFS_RC_TUNE = 4'h2;
  localparam logic [3:0] OFS_CLK_STATUS = 4'h4;
  localparam logic [3:0] OFS_OSC_CONFIG = 4'h6;
  localparam logic [3:0] OFS_TUNE_MEAS = 4'h8;
  localparam logic [7:0] KEY_HI_A = 8'h78;
  localparam logic [7:0] KEY_HI_B = 8'h9A;
  localparam logic [7:0] KEY_LO_A = 8'h46;
  localparam logic [7:0] KEY_LO_B = 8'h57;
  localparam int unsigned NOSC_LSB = 8;
  localparam int unsigned NOSC_W = 3;
  localparam int unsigned SWREQ_BIT = 0;
  localparam int unsigned SELFTUNE_ENABLE_BIT = 15;
  localparam int unsigned TUNE_SOURCE_SELECT_BIT = 12;
  localparam int unsigned TUNE_LOCK_STATUS_BIT = 11;
  localparam int unsigned LOCK_IRQ_POLARITY_BIT = 10;
  localparam int unsigned TUNE_OUT_OF_RANGE_BIT = 9;
  localparam int unsigned RANGE_IRQ_POLARITY_BIT = 8;
  localparam int unsigned TRIM_W = 6;
  localparam logic [5:0] TRIM_RST = 6'h00;
  localparam logic [15:0] OSC_CONTROL_RST = 16'h0000;
  localparam logic [15:0] OSC_CONFIG_RST = 16'h0000;
  localparam int unsigned POR_DELAY_NS = 10000;
  localparam int unsigned RST_STATE_NS = 2000;
  localparam int unsigned POR_CYC = (POR_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned RST_CYC = (RST_STATE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned OST_PERIODS = 1024;
  localparam int unsigned REG_START_CYC = 50;
  localparam int unsigned PLL_LOCK_CYC = 100;
  localparam int unsigned FRC_START_CYC = 20;
  localparam int unsigned NOM_TICKS = 8000;
  localparam int unsigned LOCK_PERMILLE = 2;
  localparam int unsigned RANGE_PERMILLE = 15;
  typedef enum logic [2:0] {
    OST_SRC_EC, OST_SRC_ECPLL, OST_SRC_XT, OST_SRC_XTPLL,
    OST_SRC_FRC, OST_SRC_FRCPLL, OST_SRC_SECONDARY_CRYSTAL_OSC, OST_SRC_LPRC
  } ost_src_t;
  typedef enum logic [1:0] {OST_RC_POR, OST_RC_BOR, OST_RC_OTHER} ost_cause_t;
endpackage : ost_pkg

//--- logic/ost_tune_if.sv
// interface: measurement path between trim loop and top
`timescale 1ns/100ps
`default_nettype none
interface ost_tune_if;
  logic run;
  logic ref_tick;
  logic [15:0] count;
  logic [5:0] trim;
  logic locked;
  logic out_range;
  modport loop (input run, input ref_tick, input count,
    output trim, output locked, output out_range);
  modport ctl (output run, output ref_tick, output count,
    input trim, input locked, input out_range);
endinterface : ost_tune_if
`default_nettype wire

//--- logic/ost_tune_loop.sv
// module: fast rc trim loop, compares rc count per reference window
`timescale 1ns/100ps
`default_nettype none
module ost_tune_loop
  import ost_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic rst_in, // async reset
  input wire logic [5:0] load_trim_in, // software trim when idle
  ost_tune_if.loop tif // measurement path
);
  import ost_pkg::*;
  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction
  logic [15:0] dev;
  localparam logic [15:0] LOCK_TOL = 16'(NOM_TICKS * LOCK_PERMILLE / 1000);
  localparam logic [15:0] RANGE_TOL = 16'(NOM_TICKS * RANGE_PERMILLE / 1000);
  always_comb dev = abs_diff(tif.count, 16'(NOM_TICKS));
  // first window after start is partial and would steer the trim wrongly
  logic primed_r;
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
      primed_r <= 1'b0;
    else if (!tif.run)
      primed_r <= 1'b0;
    else if (tif.ref_tick)
      primed_r <= 1'b1;
  // trim steps one code per window; saturates at the field ends
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
    begin
      tif.trim <= TRIM_RST;
    end
    else if (!tif.run)
    begin
      tif.trim <= load_trim_in;
    end
    else if (tif.ref_tick && primed_r && dev > LOCK_TOL)
    begin
      if (tif.count > 16'(NOM_TICKS) && tif.trim != 6'h20)
        tif.trim <= tif.trim - 6'h01;
      else if (tif.count < 16'(NOM_TICKS) && tif.trim != 6'h1F)
        tif.trim <= tif.trim + 6'h01;
    end
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
    begin
      tif.locked <= 1'b0;
      tif.out_range <= 1'b0;
    end
    else if (!tif.run)
    begin
      tif.locked <= 1'b0;
      tif.out_range <= 1'b0;
    end
    else if (tif.ref_tick && primed_r)
    begin
      tif.locked <= (dev <= LOCK_TOL);
      tif.out_range <= (dev > RANGE_TOL);
    end
  property p_range_follows;
    @(posedge ref_clk_in) disable iff (rst_in)
      (tif.run && tif.ref_tick && primed_r && dev > RANGE_TOL) |=> tif.out_range;
  endproperty
  a_range_follows: assert property (p_range_follows) else $error("range flag missed");
endmodule : ost_tune_loop
`default_nettype wire

//--- logic/ost_osc_ctrl.sv
// module: reset delays, clock release, keyed clock switch, rc self-tune
// ****************************************************************
// ****************************************************************
`timescale 1ns/100ps
`default_nettype none
module ost_osc_ctrl
  import ost_pkg::*;
#(
  parameter int unsigned OST_COUNT = OST_PERIODS,
  parameter int unsigned PLL_CYC = PLL_LOCK_CYC,
  parameter int unsigned VREG_CYC = REG_START_CYC
)
(
  input wire logic ref_clk_in, // system clock 25 MHz
  input wire logic rst_in, // async reset, active high
  input wire ost_pkg::ost_cause_t reset_cause_in, // cause of latest reset
  input wire ost_pkg::ost_src_t boot_src_in, // configured boot source
  input wire logic two_speed_in, // two-speed start-up enabled
  input wire logic osc_tick_in, // one pulse per selected osc period
  input wire logic pll_lock_in, // pll lock indication
  input wire logic secondary_crystal_osc_enabled_in, // secondary crystal running
  input wire logic usb_device_ok_in, // usb device mode, host not suspended
  input wire logic sof_tick_in, // usb start-of-frame pulse
  input wire logic secondary_crystal_osc_window_in, // secondary crystal window pulse
  input wire logic rc_tick_in, // fast rc period pulse
  input wire logic [ADDR_W-1:0] addr_in, // register address
  input wire logic [15:0] wdata_in, // write data
  input wire logic [1:0] wbyte_in, // byte lanes for write
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [15:0] rdata_out, // read data, cycle after read
  output logic sys_rst_out, // system reset
  output logic clk_release_out, // system clock released
  output ost_pkg::ost_src_t cur_src_out, // running clock source
  output logic [5:0] trim_out, // rc trim code
  output logic selftune_irq_out // self-tune interrupt
);
  import ost_pkg::*;
  typedef enum {S_POR, S_VREG, S_RST, S_OST, S_PLL, S_RUN} ost_state_t;
  function automatic logic uses_ost(input ost_src_t s);
    uses_ost = (s == OST_SRC_XT) || (s == OST_SRC_XTPLL) || (s == OST_SRC_SECONDARY_CRYSTAL_OSC);
  endfunction
  function automatic logic uses_pll(input ost_src_t s);
    uses_pll = (s == OST_SRC_ECPLL) || (s == OST_SRC_XTPLL) || (s == OST_SRC_FRCPLL);
  endfunction
  // ****************************************************************
  // reset sequencing and clock release
  // ****************************************************************
  ost_state_t state_r;
  logic [15:0] cnt_r;
  ost_src_t target_r;
  ost_src_t cur_src_r;
  logic switching_r;
  logic [15:0] osc_control_r;
  logic [15:0] osc_config_r;
  logic sw_start;
  ost_src_t sel_src;
  // selection already sits in the control register when the request arrives
  assign sel_src = ost_src_t'(osc_control_r[NOSC_LSB +: NOSC_W]);
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
    begin
      state_r <= S_POR;
      cnt_r <= 16'h0000;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
      case (state_r)
        S_POR:
        begin
          if (reset_cause_in == OST_RC_OTHER)
          begin
            state_r <= S_RST;
            cnt_r <= 16'h0000;
          end
          else if (reset_cause_in == OST_RC_BOR || cnt_r >= 16'(POR_CYC - 1))
          begin
            state_r <= S_VREG;
            cnt_r <= 16'h0000;
          end
        end
        S_VREG:
          if (cnt_r >= 16'(VREG_CYC - 1))
          begin
            state_r <= S_RST;
            cnt_r <= 16'h0000;
          end
        S_RST:
          if (cnt_r >= 16'(RST_CYC - 1))
          begin
            cnt_r <= 16'h0000;
            if (reset_cause_in == OST_RC_OTHER)
              state_r <= S_RUN;
            else if (uses_ost(target_r))
              state_r <= S_OST;
            else if (uses_pll(target_r))
              state_r <= S_PLL;
            else
              state_r <= S_RUN;
          end
        S_OST:
        begin
          cnt_r <= cnt_r + {15'h0000, osc_tick_in};
          if (osc_tick_in && cnt_r >= 16'(OST_COUNT - 1))
          begin
            cnt_r <= 16'h0000;
            state_r <= uses_pll(target_r) ? S_PLL : S_RUN;
          end
        end
        S_PLL:
          if (pll_lock_in && cnt_r >= 16'(PLL_CYC - 1))
          begin
            cnt_r <= 16'h0000;
            state_r <= S_RUN;
          end
        S_RUN:
          if (sw_start)
          begin
            cnt_r <= 16'h0000;
            state_r <= uses_ost(sel_src) ? S_OST : (uses_pll(sel_src) ? S_PLL : S_RUN);
          end
          else if (switching_r && cur_src_r != target_r && !two_speed_in)
          begin
            cnt_r <= 16'h0000;
            state_r <= uses_ost(target_r) ? S_OST : (uses_pll(target_r) ? S_PLL : S_RUN);
          end
        default:
          state_r <= S_POR;
      endcase
    end
  // target source: boot config after reset, then software selection
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
      target_r <= OST_SRC_FRC;
    else if (state_r == S_POR)
      target_r <= boot_src_in;
    else if (sw_start)
      target_r <= sel_src;
  // two-speed start runs on fast rc while the primary settles
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
    begin
      cur_src_r <= OST_SRC_FRC;
      clk_release_out <= 1'b0;
    end
    else
    begin
      if (state_r == S_RST && cnt_r >= 16'(RST_CYC - 1) && two_speed_in)
      begin
        clk_release_out <= 1'b1;
        cur_src_r <= OST_SRC_FRC;
      end
      if (state_r != S_RUN && state_r != S_OST && state_r != S_PLL && !two_speed_in)
        clk_release_out <= 1'b0;
      if ((state_r == S_OST || state_r == S_PLL) && !clk_release_out && two_speed_in)
        clk_release_out <= 1'b1;
      if (state_r == S_RUN)
      begin
        clk_release_out <= 1'b1;
        cur_src_r <= target_r;
      end
    end
  assign sys_rst_out = (state_r == S_POR) || (state_r == S_VREG) || (state_r == S_RST);
  assign cur_src_out = cur_src_r;
  // ****************************************************************
  // key-protected control register
  // ****************************************************************
  logic [1:0] hi_key_r;
  logic [1:0] lo_key_r;
  logic wr_ctl;
  logic wr_hi;
  logic wr_lo;
  logic switch_done;
  assign wr_ctl = wr_in && addr_in == OFS_OSC_CONTROL;
  assign wr_hi = wr_ctl && wbyte_in[1];
  assign wr_lo = wr_ctl && wbyte_in[0];
  assign sw_start = wr_lo && lo_key_r == 2'd2 && wdata_in[SWREQ_BIT];
  assign switch_done = switching_r && state_r == S_RUN && cur_src_r == target_r;
  // key stage 2 opens the byte for exactly the next write of any kind
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
    begin
      hi_key_r <= 2'd0;
      lo_key_r <= 2'd0;
    end
    else if (wr_in)
    begin
      hi_key_r <= (wr_hi && wdata_in[15:8] == KEY_HI_A && hi_key_r != 2'd1) ? 2'd1 :
        (wr_hi && hi_key_r == 2'd1 && wdata_in[15:8] == KEY_HI_B) ? 2'd2 : 2'd0;
      lo_key_r <= (wr_lo && wdata_in[7:0] == KEY_LO_A && lo_key_r != 2'd1) ? 2'd1 :
        (wr_lo && lo_key_r == 2'd1 && wdata_in[7:0] == KEY_LO_B) ? 2'd2 : 2'd0;
    end
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
      osc_control_r <= OSC_CONTROL_RST;
    else
    begin
      if (wr_hi && hi_key_r == 2'd2)
        osc_control_r[NOSC_LSB +: NOSC_W] <= wdata_in[NOSC_LSB +: NOSC_W];
      if (sw_start)
        osc_control_r[SWREQ_BIT] <= 1'b1;
      else if (switch_done)
        osc_control_r[SWREQ_BIT] <= 1'b0;
    end
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
      switching_r <= 1'b0;
    else if (sw_start)
      switching_r <= 1'b1;
    else if (switch_done)
      switching_r <= 1'b0;
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
      osc_config_r <= OSC_CONFIG_RST;
    else if (wr_in && addr_in == OFS_OSC_CONFIG)
      osc_config_r <= wdata_in;
  // ****************************************************************
  // self-tune control
  // ****************************************************************
  ost_tune_if tif ();
  logic st_en_r;
  logic st_src_r;
  logic lock_pol_r;
  logic range_pol_r;
  logic [5:0] sw_trim_r;
  logic [15:0] rc_cnt_r;
  logic ref_ok;
  logic ref_pulse;
  assign ref_ok = st_src_r ? usb_device_ok_in : secondary_crystal_osc_enabled_in;
  assign ref_pulse = st_src_r ? sof_tick_in : secondary_crystal_osc_window_in;
  assign tif.run = st_en_r && ref_ok;
  assign tif.ref_tick = ref_pulse;
  assign tif.count = rc_cnt_r;
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
    begin
      st_en_r <= 1'b0;
      st_src_r <= 1'b0;
      lock_pol_r <= 1'b0;
      range_pol_r <= 1'b0;
      sw_trim_r <= TRIM_RST;
    end
    else if (wr_in && addr_in == OFS_RC_TUNE)
    begin
      // byte lanes kept apart so control writes leave the trim alone
      if (wbyte_in[1])
      begin
        st_en_r <= wdata_in[SELFTUNE_ENABLE_BIT];
        st_src_r <= wdata_in[TUNE_SOURCE_SELECT_BIT];
        lock_pol_r <= wdata_in[LOCK_IRQ_POLARITY_BIT];
        range_pol_r <= wdata_in[RANGE_IRQ_POLARITY_BIT];
      end
      if (wbyte_in[0] && !tif.run)
        sw_trim_r <= wdata_in[TRIM_W-1:0];
    end
    else if (tif.run)
      sw_trim_r <= tif.trim;
  // rc periods counted per reference window
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
      rc_cnt_r <= 16'h0000;
    else if (ref_pulse || !tif.run)
      rc_cnt_r <= {15'h0000, rc_tick_in};
    else if (rc_tick_in && rc_cnt_r != 16'hFFFF)
      rc_cnt_r <= rc_cnt_r + 16'h0001;
  ost_tune_loop u_loop (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .load_trim_in(sw_trim_r),
    .tif(tif)
  );
  assign trim_out = tif.trim;
  // polarity 1 fires on presence, 0 on absence; only while enabled
  assign selftune_irq_out = st_en_r &&
    ((tif.locked == lock_pol_r) || (tif.out_range == range_pol_r));
  // ****************************************************************
  // register read
  // ****************************************************************
  logic [15:0] rd_nxt;
  always_comb
  begin
    rd_nxt = 16'h0000;
    case (addr_in)
      OFS_OSC_CONTROL: rd_nxt = {5'h00, osc_control_r[NOSC_LSB +: NOSC_W],
        7'h00, osc_control_r[SWREQ_BIT]};
      OFS_RC_TUNE: rd_nxt = {st_en_r, 2'b00, st_src_r, tif.locked, lock_pol_r,
        tif.out_range, range_pol_r, 2'b00, sw_trim_r};
      OFS_CLK_STATUS: rd_nxt = {8'h00, pll_lock_in, switching_r, clk_release_out,
        2'b00, cur_src_r};
      OFS_OSC_CONFIG: rd_nxt = osc_config_r;
      OFS_TUNE_MEAS: rd_nxt = rc_cnt_r;
      default: rd_nxt = 16'h0000;
    endcase
  end
  always_ff @(posedge ref_clk_in or posedge rst_in)
    if (rst_in)
      rdata_out <= 16'h0000;
    else if (rd_in)
      rdata_out <= rd_nxt;
    else
      rdata_out <= 16'h0000;
  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_hi_unlock;
    wr_hi && wdata_in[15:8] == KEY_HI_A ##1 wr_hi && wdata_in[15:8] == KEY_HI_B;
  endsequence
  property p_reset_asserted;
    @(posedge ref_clk_in) disable iff (rst_in)
      (state_r == S_VREG) |-> sys_rst_out;
  endproperty
  a_reset_asserted: assert property (p_reset_asserted) else $error("reset dropped early");
  property p_por_len;
    @(posedge ref_clk_in) disable iff (rst_in)
      (state_r == S_POR && cnt_r < 16'(POR_CYC - 1) && reset_cause_in == OST_RC_POR)
      |=> state_r == S_POR;
  endproperty
  a_por_len: assert property (p_por_len) else $error("power-on delay short");
  property p_short_reset;
    @(posedge ref_clk_in) disable iff (rst_in)
      (state_r == S_POR && reset_cause_in == OST_RC_OTHER) |=> state_r == S_RST;
  endproperty
  a_short_reset: assert property (p_short_reset) else $error("extra delay on warm reset");
  property p_ost_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
      (state_r == S_OST && !osc_tick_in) |=> state_r == S_OST;
  endproperty
  a_ost_hold: assert property (p_ost_hold) else $error("start-up left without period");
  property p_pll_wait;
    @(posedge ref_clk_in) disable iff (rst_in)
      (state_r == S_PLL && !pll_lock_in) |=> state_r == S_PLL;
  endproperty
  a_pll_wait: assert property (p_pll_wait) else $error("pll left before lock");
  property p_hi_write;
    @(posedge ref_clk_in) disable iff (rst_in)
      s_hi_unlock ##1 wr_hi |=> osc_control_r[NOSC_LSB +: NOSC_W] == $past(wdata_in[10:8]);
  endproperty
  a_hi_write: assert property (p_hi_write) else $error("unlocked select not taken");
  property p_locked_hi;
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_hi && hi_key_r != 2'd2) |=> $stable(osc_control_r[NOSC_LSB +: NOSC_W]);
  endproperty
  a_locked_hi: assert property (p_locked_hi) else $error("locked byte changed");
  property p_trim_frozen;
    @(posedge ref_clk_in) disable iff (rst_in)
      (tif.run && wr_in && addr_in == OFS_RC_TUNE) |=> sw_trim_r != $past(wdata_in[5:0])
      || sw_trim_r == $past(tif.trim);
  endproperty
  a_trim_frozen: assert property (p_trim_frozen) else $error("trim written while tuning");
  property p_done_clears;
    @(posedge ref_clk_in) disable iff (rst_in)
      switch_done && !sw_start |=> !osc_control_r[SWREQ_BIT];
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("switch request not cleared");
endmodule : ost_osc_ctrl
`default_nettype wire

//--- tb/ost_far_model.sv
// far-side model: oscillator ticks, pll lock, reference windows, rc ticks
`timescale 1ns/100ps
`default_nettype none
module ost_far_model (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // async reset, active high
  input wire logic [15:0] win_in, // reference window length in clocks
  output logic osc_tick_out, // one pulse per oscillator period
  output logic pll_lock_out, // pll lock level
  output logic ref_tick_out, // sof or crystal window pulse
  output logic rc_tick_out // fast rc period pulse
);
  // ****************************************************************
  // oscillator and pll
  // ****************************************************************
  logic [1:0] div_r;
  logic [5:0] lock_r;
  logic [15:0] win_r;
  // lock takes 40 oscillator periods, so short resets see it late
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_r <= 2'h0;
      lock_r <= 6'h00;
    end
    else
    begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3 && lock_r != 6'h28)
        lock_r <= lock_r + 6'h01;
    end
  end
  assign osc_tick_out = (div_r == 2'h3);
  assign pll_lock_out = (lock_r == 6'h28);
  // one reference feeds both sources; rc runs one tick a clock
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      win_r <= 16'h0000;
    else if (win_r + 16'h0001 >= win_in)
      win_r <= 16'h0000;
    else
      win_r <= win_r + 16'h0001;
  end
  assign ref_tick_out = (win_r == 16'h0000) && !rst_in;
  assign rc_tick_out = !rst_in;
endmodule // ost_far_model
`default_nettype wire

//--- tb/tb_top.sv
// bench: reset timing, keyed clock switch and rc self-tune against a model
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_top;
  import ost_pkg::*;
  localparam int unsigned OSTN = 16;
  localparam int unsigned PLLN = 8;
  localparam int unsigned VREGN = 10;
  localparam int unsigned WIN_WAIT = 2 * 8400;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ost_cause_t cause = OST_RC_POR;
  ost_src_t boot = OST_SRC_XTPLL;
  logic two_spd = 1'b0;
  logic secondary_crystal_osc_en = 1'b0;
  logic usb_ok = 1'b0;
  logic [15:0] win = 16'h1F40;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [1:0] wbyte = 2'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata, d, d0, t;
  logic sys_rst, rel, irq, osc_tick, pll_lock, ref_tick, rc_tick;
  ost_src_t cur;
  logic [5:0] trim;
  int err_count = 0;
  int n_checks = 0;
  int n, k, ticks;
  ost_osc_ctrl #(.OST_COUNT(OSTN), .PLL_CYC(PLLN), .VREG_CYC(VREGN)) DUT (
    .ref_clk_in(clk), .rst_in(rst), .reset_cause_in(cause), .boot_src_in(boot),
    .two_speed_in(two_spd), .osc_tick_in(osc_tick), .pll_lock_in(pll_lock),
    .secondary_crystal_osc_enabled_in(secondary_crystal_osc_en), .usb_device_ok_in(usb_ok), .sof_tick_in(ref_tick),
    .secondary_crystal_osc_window_in(ref_tick), .rc_tick_in(rc_tick), .addr_in(addr), .wdata_in(wdata),
    .wbyte_in(wbyte), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sys_rst_out(sys_rst),
    .clk_release_out(rel), .cur_src_out(cur), .trim_out(trim), .selftune_irq_out(irq));
  ost_far_model u_far (.clk_in(clk), .rst_in(rst), .win_in(win), .osc_tick_out(osc_tick),
    .pll_lock_out(pll_lock), .ref_tick_out(ref_tick), .rc_tick_out(rc_tick));
  always #20 clk = ~clk;
  // oscillator periods seen between system reset and clock release
  always @(posedge clk)
    if (rst || sys_rst) ticks <= 0;
    else if (osc_tick && !rel) ticks <= ticks + 1;
  // ****************************************************************
  // bus and sequence tasks
  // ****************************************************************
  task automatic bus(input logic w, input logic r, input logic [3:0] a,
                     input logic [15:0] v, input logic [1:0] l);
  begin
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= v;
    wbyte <= l;
    @(posedge clk);
  end
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
  begin
    bus(1'b0, 1'b1, a, 16'h0000, 2'h0);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  end
  endtask
  // bad corrupts the second key of each pair
  task automatic switch_to(input logic [2:0] s, input logic [15:0] bad);
    logic [15:0] seq [6];
  begin
    seq = '{16'h7800, 16'h9A00, {5'h00, s, 8'h00}, 16'h0046, 16'h0057, 16'h0001};
    seq[1] ^= bad;
    seq[4] ^= bad;
    for (k = 0; k < 6; k++)
      bus(1'b1, 1'b0, OFS_OSC_CONTROL, seq[k], (k < 3) ? 2'h2 : 2'h1);
    bus(1'b0, 1'b0, 4'h0, 16'h0000, 2'h0);
  end
  endtask
  task automatic do_reset(input ost_cause_t c, input logic ts, input int exp_len);
  begin
    cause <= c;
    two_spd <= ts;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    @(posedge clk) #1;
    while (sys_rst === 1'b1 && n < 2000) @(posedge clk) #1 n++;
    `CHK(1'(n + 2 >= exp_len && n <= exp_len + 2), 1'b1)
    while (rel !== 1'b1 && n < 4000) @(posedge clk) #1 n++;
    if (ts) `CHK(cur, OST_SRC_FRC)
    else if (c == OST_RC_POR) `CHK(1'(ticks >= OSTN), 1'b1)
    while (cur !== boot && n < 6000) @(posedge clk) #1 n++;
    `CHK(cur, boot)
  end
  endtask
  task automatic complete_run;
  begin
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    #(40 * 95000);
    err_count++;
    complete_run();
  end
  initial
  begin
    k = $urandom(32'hAB91D642);
    t = 16'(8 + $urandom % 48);
    do_reset(OST_RC_POR, 1'b0, POR_CYC + VREGN + RST_CYC);
    do_reset(OST_RC_BOR, 1'b1, VREGN + RST_CYC);
    do_reset(OST_RC_OTHER, 1'b0, RST_CYC);
    rd_reg(OFS_OSC_CONTROL, d0);
    switch_to(3'(OST_SRC_FRC), 16'h0101);
    rd_reg(OFS_OSC_CONTROL, d);
    `CHK({d[10:8], d[0]}, {d0[10:8], 1'b0})
    switch_to(3'(OST_SRC_FRC), 16'h0000);
    rd_reg(OFS_OSC_CONTROL, d);
    `CHK({d[10:8], d[0]}, {3'(OST_SRC_FRC), 1'b1})
    n = 0;
    while (cur !== OST_SRC_FRC && n < 3000) @(posedge clk) #1 n++;
    rd_reg(OFS_OSC_CONTROL, d);
    `CHK({cur, d[0]}, {OST_SRC_FRC, 1'b0})
    bus(1'b1, 1'b0, OFS_RC_TUNE, t, 2'h3);
    rd_reg(OFS_RC_TUNE, d);
    `CHK({d[5:0], trim}, {t[5:0], t[5:0]})
    // usb reference chosen while usb is down: trim must hold
    secondary_crystal_osc_en <= 1'b1;
    win <= 16'h206C;
    bus(1'b1, 1'b0, OFS_RC_TUNE, 16'h9000, 2'h2);
    bus(1'b0, 1'b0, 4'h0, 16'h0000, 2'h0);
    repeat (WIN_WAIT) @(posedge clk);
    `CHK(trim, t[5:0])
    bus(1'b1, 1'b0, OFS_RC_TUNE, 16'h8000, 2'h2);
    bus(1'b0, 1'b0, 4'h0, 16'h0000, 2'h0);
    repeat (WIN_WAIT) @(posedge clk);
    rd_reg(OFS_RC_TUNE, d);
    `CHK({d[11], d[9], 1'(trim !== t[5:0])}, 3'b011)
    win <= 16'h1F40;
    repeat (WIN_WAIT) @(posedge clk);
    rd_reg(OFS_RC_TUNE, d);
    `CHK({d[11], d[9]}, 2'b10)
    t = {10'h000, trim};
    bus(1'b1, 1'b0, OFS_RC_TUNE, {10'h200, ~trim}, 2'h3);
    rd_reg(OFS_RC_TUNE, d);
    `CHK(d[5:0], t[5:0])
    for (k = 0; k < 5; k++)
    begin
      bus(1'b1, 1'b0, OFS_RC_TUNE, {1'(k < 4), 4'h0, k[1], 1'b0, k[0], 8'h00}, 2'h2);
      rd_reg(OFS_RC_TUNE, d);
      `CHK({d[10], d[8], irq}, {k[1], k[0], 1'(k < 4 && (k[1] || !k[0]))})
    end
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
